// *** hdl/rwdt_pkg.sv ***
// Constants shared by the runaway watchdog: register map, field layout,
// reset values, command codes and timing counts.
// Assumes a byte-addressed register port with 8-bit data.
package rwdt_pkg;
   localparam logic [31:0] MODE_ADDR = 32'h4004_0000;
   localparam logic [31:0] CMD_ADDR = 32'h4004_0004;
   localparam int ENABLE_BIT = 7;
   localparam int SEL_HI = 6;
   localparam int SEL_LO = 4;
   localparam int IDLE_RUN_BIT = 2;
   localparam int RESET_CONNECT_BIT = 1;
   localparam int STATUS_BIT = 0;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic ENABLE_RESET = 1'b1;
   localparam logic RESET_CONNECT_RESET = 1'b1;
   localparam logic IDLE_RUN_RESET = 1'b0;
   localparam logic [2:0] SEL_MAX = 3'h5;
   localparam int TAP_COUNT = 6;
   localparam int TAP_BASE_DEFAULT = 16;
   localparam logic [7:0] CODE_DISABLE = 8'hB1;
   localparam logic [7:0] CODE_CLEAR = 8'h4E;
   localparam int RESET_HOLD_STATES = 32;
   localparam logic [5:0] RESET_HOLD_COUNT = 6'(RESET_HOLD_STATES);
endpackage

// *** hdl/rwdt_counter.sv ***
// Binary counter of the runaway watchdog with selectable overflow tap.
// Assumes clear, advance and tap select are synchronous to clk.
`timescale 1ns/10ps
module rwdt_counter #(
   parameter int TAP_BASE = rwdt_pkg::TAP_BASE_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic advance,
   input wire logic [2:0] tap_sel,
   output logic overflow,
   output logic [TAP_BASE+9:0] count
);
   import rwdt_pkg::*;
   logic [TAP_COUNT-1:0] tap_hit;

   // Tap k is reached when the low TAP_BASE+2k bits are all ones
   genvar k;
   generate
      for (k = 0; k < TAP_COUNT; k++) begin : g_tap
         assign tap_hit[k] = &count[TAP_BASE+2*k-1:0];
      end
   endgenerate

   // Unused codes above the last tap fall back to the longest interval
   always_comb begin
      if (tap_sel > SEL_MAX) begin
         overflow = advance && tap_hit[TAP_COUNT-1];
      end else begin
         overflow = advance && tap_hit[tap_sel];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else if (clear || overflow) begin
         count <= '0;
      end else if (advance) begin
         count <= count + 1'b1;
      end
   end
endmodule

// *** hdl/rwdt_top.sv ***
// Runaway watchdog: mode and command registers, counter control, interrupt,
// runaway pin and chip reset request.
// Assumes a single-cycle strobe register port and synchronous mode inputs.
`timescale 1ns/10ps
module rwdt_top #(
   parameter int TAP_BASE = rwdt_pkg::TAP_BASE_DEFAULT
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [31:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [7:0] RDATA,
   input wire logic STOP_MODE,
   input wire logic IDLE_MODE,
   input wire logic DEBUG_MODE,
   output logic RUNAWAY_NMI,
   output logic RUNAWAY_OUT_PIN_B,
   output logic CHIP_RESET_REQ
);
   import rwdt_pkg::*;

   logic [2:0] detect_time_sel;
   logic timer_enable_bit;
   logic idle_run_select;
   logic overflow_reset_connect;
   logic running;
   logic mode_wr;
   logic mode_rd;
   logic cmd_wr;
   logic clear_cmd;
   logic disable_cmd;
   logic advance;
   logic counter_clear;
   logic overflow;
   logic [TAP_BASE+9:0] count;
   logic [5:0] hold_cnt;
   logic [5:0] next_hold;
   logic after_reset;

   assign mode_wr = WR_STB && (ADDR == MODE_ADDR);
   assign mode_rd = RD_STB && (ADDR == MODE_ADDR);
   assign cmd_wr = WR_STB && (ADDR == CMD_ADDR);
   assign clear_cmd = cmd_wr && (WDATA == CODE_CLEAR);
   assign disable_cmd = cmd_wr && (WDATA == CODE_DISABLE);

   // Mode register fields
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         detect_time_sel <= SEL_RESET;
         timer_enable_bit <= ENABLE_RESET;
         idle_run_select <= IDLE_RUN_RESET;
         overflow_reset_connect <= RESET_CONNECT_RESET;
      end else if (mode_wr) begin
         detect_time_sel <= WDATA[SEL_HI:SEL_LO];
         timer_enable_bit <= WDATA[ENABLE_BIT];
         idle_run_select <= WDATA[IDLE_RUN_BIT];
         overflow_reset_connect <= WDATA[RESET_CONNECT_BIT];
      end
   end

   // Run state: the two-step disable guards against a runaway stopping the timer
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         running <= 1'b1;
      end else if (mode_wr && WDATA[ENABLE_BIT]) begin
         running <= 1'b1;
      end else if (disable_cmd && !timer_enable_bit) begin
         running <= 1'b0;
      end
   end

   // Bus release is not an input: counting ignores it entirely
   assign advance = running && !STOP_MODE && !DEBUG_MODE
                    && !(IDLE_MODE && !idle_run_select);
   assign counter_clear = clear_cmd || disable_cmd || STOP_MODE;

   rwdt_counter #(
      .TAP_BASE(TAP_BASE)
   ) u_counter (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .clear(counter_clear),
      .advance(advance),
      .tap_sel(detect_time_sel),
      .overflow(overflow),
      .count(count)
   );

   // Interrupt is a one-cycle pulse per overflow
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         RUNAWAY_NMI <= 1'b0;
      end else begin
         RUNAWAY_NMI <= overflow;
      end
   end

   // Overflow wins over a clear written in the same cycle
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         RUNAWAY_OUT_PIN_B <= 1'b1;
      end else if (overflow) begin
         RUNAWAY_OUT_PIN_B <= 1'b0;
      end else if (clear_cmd) begin
         RUNAWAY_OUT_PIN_B <= 1'b1;
      end
   end

   // Reset hold is counted on the core clock; the gear is assumed undivided
   always_comb begin
      next_hold = hold_cnt;
      if (overflow && overflow_reset_connect) begin
         next_hold = RESET_HOLD_COUNT;
      end else if (hold_cnt != 6'h00) begin
         next_hold = hold_cnt - 6'h01;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hold_cnt <= 6'h00;
         CHIP_RESET_REQ <= 1'b0;
      end else begin
         hold_cnt <= next_hold;
         CHIP_RESET_REQ <= (next_hold != 6'h00);
      end
   end

   // Read data stand for one cycle only; command and unmapped read zero
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         RDATA <= 8'h00;
      end else if (mode_rd) begin
         RDATA <= 8'h00;
         RDATA[ENABLE_BIT] <= timer_enable_bit;
         RDATA[SEL_HI:SEL_LO] <= detect_time_sel;
         RDATA[IDLE_RUN_BIT] <= idle_run_select;
         RDATA[RESET_CONNECT_BIT] <= overflow_reset_connect;
         RDATA[STATUS_BIT] <= running;
      end else begin
         RDATA <= 8'h00;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         after_reset <= 1'b1;
      end else begin
         after_reset <= 1'b0;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);

   chk_reset_mode_values: assert property (
      after_reset |-> (detect_time_sel == SEL_RESET) && timer_enable_bit
                      && overflow_reset_connect && running)
      else $error("mode fields wrong after reset");

   chk_count_starts: assert property (
      after_reset && advance && !counter_clear |=> (count == 1))
      else $error("counter did not start after reset");

   chk_disable_sequence: assert property (
      $fell(running) |-> $past(disable_cmd) && !$past(timer_enable_bit))
      else $error("timer stopped without the two-step sequence");

   chk_enable_restores: assert property (
      mode_wr && WDATA[ENABLE_BIT] |=> running ##1 (RDATA[STATUS_BIT] || !$past(mode_rd)))
      else $error("enable write did not resume the timer");

   chk_clear_zeroes: assert property (
      clear_cmd || disable_cmd |=> (count == 0))
      else $error("command code did not clear the counter");

   chk_overflow_events: assert property (
      overflow |=> RUNAWAY_NMI && !RUNAWAY_OUT_PIN_B)
      else $error("overflow without interrupt and low pin");

   chk_stop_idle: assert property (
      STOP_MODE |=> (count == 0) && !RUNAWAY_NMI ##1 !RUNAWAY_NMI)
      else $error("counter active in stop mode");

   chk_debug_holds: assert property (
      DEBUG_MODE && !STOP_MODE && !clear_cmd && !disable_cmd |=> $stable(count))
      else $error("counter moved in debug mode");

   chk_reset_hold_len: assert property (
      $rose(CHIP_RESET_REQ) |-> ##31 CHIP_RESET_REQ ##1 !CHIP_RESET_REQ)
      else $error("chip reset not held 32 cycles");

   chk_reset_needs_connect: assert property (
      $rose(CHIP_RESET_REQ) |-> $past(overflow) && $past(overflow_reset_connect))
      else $error("chip reset without connection");

   chk_pin_high_on_clear: assert property (
      clear_cmd && !overflow |=> RUNAWAY_OUT_PIN_B)
      else $error("pin not released by clear code");

   chk_other_codes_inert: assert property (
      cmd_wr && !clear_cmd && !disable_cmd && !STOP_MODE && !overflow
      |=> $stable(running) && (count == $past(count) + $past(advance)))
      else $error("other command code had an effect");

   // Quiet-state and readback guards; a slip here stays silent in normal counting
   chk_nmi_one_pulse: assert property (
      RUNAWAY_NMI |=> !RUNAWAY_NMI)
      else $error("interrupt longer than one cycle");

   chk_pin_stays_low: assert property (
      !RUNAWAY_OUT_PIN_B && !clear_cmd |=> !RUNAWAY_OUT_PIN_B)
      else $error("runaway pin released without clear code");

   chk_enable_clear_alone: assert property (
      mode_wr && !WDATA[ENABLE_BIT] && running |=> running)
      else $error("clearing the enable bit alone stopped the timer");

   chk_disable_needs_order: assert property (
      disable_cmd && timer_enable_bit && running |=> running)
      else $error("disable code stopped the timer with enable set");

   chk_disabled_no_overflow: assert property (
      !running |-> !overflow)
      else $error("overflow while disabled");

   chk_enable_bit_lands: assert property (
      mode_wr && WDATA[ENABLE_BIT] |=> timer_enable_bit)
      else $error("enable bit write lost");

   chk_status_readback: assert property (
      mode_rd |=> (RDATA[STATUS_BIT] == $past(running))
                  && (RDATA[ENABLE_BIT] == $past(timer_enable_bit)))
      else $error("mode readback does not match state");

   chk_no_reset_unconnected: assert property (
      overflow && !overflow_reset_connect && !CHIP_RESET_REQ |=> !CHIP_RESET_REQ)
      else $error("chip reset requested while not connected");

   chk_disabled_count_zero: assert property (
      !running |-> (count == 0))
      else $error("counter not zero while disabled");

   chk_outputs_after_reset: assert property (
      after_reset |-> RUNAWAY_OUT_PIN_B && !RUNAWAY_NMI && !CHIP_RESET_REQ)
      else $error("outputs not idle after reset");

   chk_count_advances: assert property (
      advance && !counter_clear && !overflow |=> (count == $past(count) + 1))
      else $error("counter did not advance");

   chk_stop_no_reset: assert property (
      STOP_MODE && !CHIP_RESET_REQ |=> !CHIP_RESET_REQ)
      else $error("chip reset raised in stop mode");

   chk_idle_pauses: assert property (
      IDLE_MODE && !idle_run_select && !STOP_MODE && !clear_cmd && !disable_cmd
      |=> $stable(count))
      else $error("counter moved in idle without idle-run");

   chk_debug_no_events: assert property (
      DEBUG_MODE |-> !overflow)
      else $error("overflow in debug mode");

   chk_req_after_overflow: assert property (
      overflow && overflow_reset_connect |=> CHIP_RESET_REQ)
      else $error("connected overflow gave no chip reset");

   chk_read_one_cycle: assert property (
      !RD_STB |=> (RDATA == 8'h00))
      else $error("read data stood longer than one cycle");

   chk_cmd_reads_zero: assert property (
      RD_STB && (ADDR == CMD_ADDR) |=> (RDATA == 8'h00))
      else $error("command register read not zero");

   cov_overflow_nmi: cover property (overflow ##1 RUNAWAY_NMI);
   cov_chip_reset: cover property ($rose(CHIP_RESET_REQ));
   cov_disable: cover property ($fell(running));
   cov_pin_recover: cover property ($rose(RUNAWAY_OUT_PIN_B));
   cov_idle_run: cover property (IDLE_MODE && idle_run_select && overflow);
endmodule

// *** bench/rwdt_host_model.sv ***
// Host side model: the core's non-maskable interrupt input and reset logic.
// Assumes the watchdog outputs are registered on the same core clock.
`timescale 1ns/10ps
module rwdt_host_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic nmi,
   input wire logic reset_req,
   output int nmi_count,
   output int req_len
);
   int run;
   // The oscillator in this model never stops, so reset timing stays sound
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_count <= 0;
      end else if (nmi === 1'b1) begin
         nmi_count <= nmi_count + 1;
      end
   end
   // Records how long the core was last held in reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run <= 0;
         req_len <= 0;
      end else if (reset_req === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         req_len <= run;
         run <= 0;
      end
   end
endmodule

// *** bench/rwdt_tb_top.sv ***
// Self-checking bench for the runaway watchdog.
// Assumes the register port and host model; shortest tap is 2^4 cycles.
`timescale 1ns/10ps
module runaway_watchdog_timer_tb_top;
   import rwdt_pkg::*;
   logic CORE_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic [31:0] ADDR = 32'h0;
   logic [7:0] WDATA = 8'h00;
   logic STOP_MODE = 1'b0;
   logic IDLE_MODE = 1'b0;
   logic DEBUG_MODE = 1'b0;
   logic [7:0] RDATA;
   logic RUNAWAY_NMI;
   logic RUNAWAY_OUT_PIN_B;
   logic CHIP_RESET_REQ;
   int fail_count = 0;
   int n_checks = 0;
   int c;
   always #10 CORE_CLK = ~CORE_CLK;
   rwdt_top #(.TAP_BASE(4)) DUT (.CORE_CLK, .RST_B, .ADDR, .WDATA, .WR_STB, .RD_STB,
      .RDATA, .STOP_MODE, .IDLE_MODE, .DEBUG_MODE, .RUNAWAY_NMI, .RUNAWAY_OUT_PIN_B,
      .CHIP_RESET_REQ);
   rwdt_host_model HOST (.clk(CORE_CLK), .rst_b(RST_B), .nmi(RUNAWAY_NMI),
      .reset_req(CHIP_RESET_REQ), .nmi_count(), .req_len());
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'b1;
      @(posedge CORE_CLK);
      WR_STB <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] exp);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge CORE_CLK);
      RD_STB <= 1'b0;
      @(negedge CORE_CLK);
      chk(RDATA, exp);
   endtask
   // Clear, then the runaway pin must be back high next cycle
   task automatic clr;
      wr(CMD_ADDR, CODE_CLEAR);
      cyc(1);
      chk({7'h0, RUNAWAY_OUT_PIN_B}, 8'h01);
   endtask
   task automatic nmi_in(input int lo, input int hi);
      int n;
      n = 0;
      while (RUNAWAY_NMI !== 1'b1 && n <= hi) begin
         @(negedge CORE_CLK);
         n++;
      end
      chk(8'(n >= lo && n <= hi), 8'h01);
      chk({7'h0, RUNAWAY_OUT_PIN_B}, 8'h00);
   endtask
   task automatic quiet(input int n);
      c = HOST.nmi_count;
      cyc(n);
      chk(8'(HOST.nmi_count - c), 8'h00);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #400us;
      fail_count++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      nmi_in(14, 19);
      rd(MODE_ADDR, 8'h83);
      rd(CMD_ADDR, 8'h00);
      rd(32'h4004_0008, 8'h00);
      wr(MODE_ADDR, 8'h92);
      clr();
      nmi_in(61, 66);
      chk({7'h0, CHIP_RESET_REQ}, 8'h01);
      cyc(40);
      chk(8'(HOST.req_len), 8'h20);
      clr();
      $display("test reset and overflow done");
      for (int s = 0; s < 3; s++) begin
         wr(MODE_ADDR, {1'b1, 3'(s), 4'h0});
         clr();
         nmi_in((16 << (2 * s)) - 3, (16 << (2 * s)) + 2);
         chk({7'h0, CHIP_RESET_REQ}, 8'h00);
         cyc(3);
         chk({7'h0, RUNAWAY_OUT_PIN_B}, 8'h00);
         clr();
      end
      $display("test detection times done");
      wr(MODE_ADDR, 8'h80);
      c = HOST.nmi_count;
      repeat (10) begin
         clr();
         cyc(8);
      end
      chk(8'(HOST.nmi_count - c), 8'h00);
      wr(CMD_ADDR, 8'h55);
      nmi_in(2, 10);
      wr(CMD_ADDR, CODE_DISABLE);
      nmi_in(15, 17);
      clr();
      wr(MODE_ADDR, 8'h00);
      nmi_in(10, 18);
      wr(CMD_ADDR, CODE_DISABLE);
      quiet(100);
      rd(MODE_ADDR, 8'h00);
      wr(MODE_ADDR, 8'h80);
      nmi_in(13, 19);
      clr();
      $display("test commands done");
      @(posedge CORE_CLK);
      STOP_MODE <= 1'b1;
      quiet(100);
      @(posedge CORE_CLK);
      STOP_MODE <= 1'b0;
      nmi_in(16, 18);
      clr();
      cyc(6);
      @(posedge CORE_CLK);
      DEBUG_MODE <= 1'b1;
      quiet(100);
      @(posedge CORE_CLK);
      DEBUG_MODE <= 1'b0;
      nmi_in(8, 10);
      clr();
      @(posedge CORE_CLK);
      IDLE_MODE <= 1'b1;
      quiet(100);
      @(posedge CORE_CLK);
      IDLE_MODE <= 1'b0;
      wr(MODE_ADDR, 8'h84);
      clr();
      @(posedge CORE_CLK);
      IDLE_MODE <= 1'b1;
      nmi_in(13, 19);
      @(posedge CORE_CLK);
      IDLE_MODE <= 1'b0;
      $display("test power modes done");
      test_done();
   end
endmodule
